//--- hdl/pdc_pkg.sv
/*
  pdc_pkg: register map, field positions, reset values and counts
  for the pci dma address/count/configuration block.
  assumes a 32-bit classic wishbone slave, byte addresses.
*/
package pdc_pkg;

  localparam int          PDC_AW         = 16;
  localparam int          PDC_DW         = 32;
  // register byte offsets
  localparam logic [15:0] PDC_OFS_ADDR   = 16'hD208;
  localparam logic [15:0] PDC_OFS_COUNT  = 16'hD20C;
  localparam logic [15:0] PDC_OFS_CFG    = 16'hD210;
  localparam logic [15:0] PDC_OFS_CTL    = 16'hD214;
  localparam logic [15:0] PDC_OFS_STAT   = 16'hD218;
  // dma_config fields
  localparam int          PDC_CFG_CLR    = 21;
  localparam int          PDC_CFG_BORD   = 20;
  localparam int          PDC_CFG_BINH   = 19;
  // control register fields
  localparam int          PDC_CTL_START  = 0;
  localparam int          PDC_CTL_DIR    = 1;
  localparam int          PDC_CTL_BMODE  = 2;
  // status register fields
  localparam int          PDC_ST_ACTIVE  = 0;
  localparam int          PDC_ST_STAGE   = 1;
  localparam int          PDC_ST_OVALID  = 2;
  localparam int          PDC_ST_LVL_LSB = 8;
  // address and count fields
  localparam logic [31:0] PDC_ADDR_MASK  = 32'hFFFF_FFFC;
  localparam logic [31:0] PDC_COUNT_MASK = 32'h00FF_FFFC;
  localparam int          PDC_COUNT_W    = 24;
  localparam logic [23:0] PDC_STEP       = 24'h00_0004;
  localparam logic [31:0] PDC_ASTEP      = 32'h0000_0004;
  // burst needs four words left and a four-word aligned address
  localparam logic [23:0] PDC_BURST_MIN  = 24'h00_0010;
  localparam int          PDC_FIFO_DEPTH = 32;
  localparam logic        PDC_RST_BIT    = 1'b0;

endpackage : pdc_pkg

//--- hdl/pdc_fifo.sv
/*
  pdc_fifo: synchronous word fifo with valid/ready on both sides
  and a level-sensitive clear of both pointers and the level.
  assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module pdc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic                       clock_in,
  input  wire logic                       srst_in,
  input  wire logic                       clear_in,
  input  wire logic                       in_valid_in,
  input  wire logic [WIDTH-1:0]           in_data_in,
  output logic                            in_ready_out,
  output logic                            out_valid_out,
  output logic [WIDTH-1:0]                out_data_out,
  input  wire logic                       out_ready_in,
  output logic [$clog2(DEPTH+1)-1:0]      level_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("pdc_fifo depth must be a power of two");
    end
  endgenerate

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [LW-1:0] cnt;
  } pdc_fifo_s;

  pdc_fifo_s        q;
  pdc_fifo_s        next_q;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_out  = (q.cnt != LW'(DEPTH));
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out  = mem[q.rp];
  assign level_out     = q.cnt;
  assign push          = in_valid_in && in_ready_out && !clear_in;
  assign pop           = out_valid_out && out_ready_in && !clear_in;

  always_comb begin
    next_q = q;
    if (push) begin
      next_q.wp = q.wp + PW'(1);
    end
    if (pop) begin
      next_q.rp = q.rp + PW'(1);
    end
    next_q.cnt = q.cnt + LW'(push) - LW'(pop);
    // clear wins over any transfer in the same cycle
    if (clear_in) begin
      next_q = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
    if (push) begin
      mem[q.wp] <= in_data_in;
    end
  end

endmodule : pdc_fifo

//--- hdl/pdc_engine.sv
/*
  pdc_engine: pci dma transfer address, byte count and configuration
  registers on a classic wishbone slave, with the word data path
  (byte order stage, fifo, output stage) that they steer.
  assumes source and sink stream logic on the same clock; the
  far sides keep their own valid/ready handshakes.
*/
`timescale 1ns/1ps
module pdc_engine
  import pdc_pkg::*;
#(
  parameter int FIFO_DEPTH = PDC_FIFO_DEPTH
) (
  input  wire logic              clock_in,
  input  wire logic              srst_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [PDC_AW-1:0] wb_adr_in,
  input  wire logic [31:0]       wb_dat_in,
  input  wire logic [3:0]        wb_sel_in,
  output logic      [31:0]       wb_dat_out,
  output logic                   wb_ack_out,
  input  wire logic [31:0]       src_data_in,
  input  wire logic              src_valid_in,
  output logic                   src_ready_out,
  output logic      [31:0]       dst_data_out,
  output logic                   dst_valid_out,
  input  wire logic              dst_ready_in,
  output logic      [31:0]       pci_addr_out,
  output logic                   pci_write_out,
  output logic                   sysbus_burst_out,
  output logic                   busy_out
);
  localparam int LW = $clog2(FIFO_DEPTH + 1);

  generate
    if (FIFO_DEPTH < 2) begin : g_bad
      $error("pdc_engine fifo depth too small");
    end
  endgenerate

  typedef struct packed {
    logic [31:0] addr;
    logic [23:0] count;
    logic        fclr;
    logic        bord;
    logic        binh;
    logic        dir;
    logic        bmode;
    logic        active;
    logic        ack;
    logic [31:0] rdat;
    logic        sready;
    logic        stg_v;
    logic [31:0] stg_d;
    logic        ov;
    logic [31:0] od;
    logic        burst;
  } pdc_state_s;

  pdc_state_s  q;
  pdc_state_s  next_q;
  pdc_state_s  rst_q;
  logic        wr;
  logic        rd;
  logic        take;
  logic        push;
  logic        pop;
  logic        out_go;
  logic        f_ready;
  logic        f_valid;
  logic [31:0] f_data;
  logic [LW-1:0] f_level;
  logic [31:0] stat;

  ////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] swap32(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction : swap32

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////
  // fifo in the data path; its ready stalls the staging register

  pdc_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .srst_in       (srst_in),
    .clear_in      (q.fclr),
    .in_valid_in   (q.stg_v),
    .in_data_in    (q.stg_d),
    .in_ready_out  (f_ready),
    .out_valid_out (f_valid),
    .out_data_out  (f_data),
    .out_ready_in  (pop),
    .level_out     (f_level)
  );

  ////////////////////////////////////////////////////////////////////
  // handshakes

  assign wr     = wb_cyc_in && wb_stb_in && !q.ack && wb_we_in;
  assign rd     = wb_cyc_in && wb_stb_in && !q.ack && !wb_we_in;
  assign take   = src_valid_in && q.sready;
  assign push   = q.stg_v && f_ready && !q.fclr;
  assign out_go = q.ov && dst_ready_in;
  assign pop    = f_valid && (!q.ov || dst_ready_in) && !q.fclr;

  always_comb begin
    stat = '0;
    stat[PDC_ST_ACTIVE] = q.active;
    stat[PDC_ST_STAGE]  = q.stg_v;
    stat[PDC_ST_OVALID] = q.ov;
    stat[PDC_ST_LVL_LSB +: LW] = f_level;
  end

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_q     = q;
    next_q.ack = wb_cyc_in && wb_stb_in && !q.ack;

    // source word: order bytes, stage it, count the bytes moved
    if (push) begin
      next_q.stg_v = 1'b0;
    end
    if (take) begin
      next_q.stg_v = 1'b1;
      // one keeps the word as is, zero reverses its bytes
      next_q.stg_d = q.bord ? src_data_in
                            : swap32(src_data_in);
      next_q.count = q.count - PDC_STEP;
      if (q.count == PDC_STEP) begin
        next_q.active = 1'b0;
      end
    end

    // output stage; the pci-side address follows the words out
    if (out_go) begin
      next_q.ov   = 1'b0;
      next_q.addr = q.addr + PDC_ASTEP;
    end
    if (pop) begin
      next_q.ov = 1'b1;
      next_q.od = f_data;
    end
    if (q.fclr) begin
      next_q.stg_v = 1'b0;
    end

    // register writes take effect with the ack
    if (wr) begin
      unique case (wb_adr_in)
        PDC_OFS_ADDR: begin
          next_q.addr = merge(q.addr, wb_dat_in, wb_sel_in)
                        & PDC_ADDR_MASK;
        end
        PDC_OFS_COUNT: begin
          next_q.count = PDC_COUNT_W'(
            merge({8'h00, q.count}, wb_dat_in, wb_sel_in)
            & PDC_COUNT_MASK);
        end
        PDC_OFS_CFG: begin
          if (wb_sel_in[2]) begin
            // stays set until software writes it back to zero
            next_q.fclr = wb_dat_in[PDC_CFG_CLR];
            next_q.bord = wb_dat_in[PDC_CFG_BORD];
            next_q.binh = wb_dat_in[PDC_CFG_BINH];
          end
        end
        PDC_OFS_CTL: begin
          if (wb_sel_in[0]) begin
            next_q.dir   = wb_dat_in[PDC_CTL_DIR];
            next_q.bmode = wb_dat_in[PDC_CTL_BMODE];
            // a zero count never starts a transfer
            if (wb_dat_in[PDC_CTL_START] && next_q.count != '0) begin
              next_q.active = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // read data is captured with the ack; unmapped reads return zero
    next_q.rdat = '0;
    if (rd) begin
      unique case (wb_adr_in)
        PDC_OFS_ADDR:  next_q.rdat = q.addr;
        PDC_OFS_COUNT: next_q.rdat = {8'h00, q.count};
        PDC_OFS_CFG: begin
          next_q.rdat[PDC_CFG_CLR]  = q.fclr;
          next_q.rdat[PDC_CFG_BORD] = q.bord;
          next_q.rdat[PDC_CFG_BINH] = q.binh;
        end
        PDC_OFS_CTL: begin
          next_q.rdat[PDC_CTL_DIR]   = q.dir;
          next_q.rdat[PDC_CTL_BMODE] = q.bmode;
        end
        PDC_OFS_STAT:  next_q.rdat = stat;
        default:       next_q.rdat = '0;
      endcase
    end

    // registered ready: take only while counting and the stage is free
    next_q.sready = next_q.active && !next_q.stg_v && !next_q.fclr;

    // system-bus burst only if mode asks, inhibit clear, room allows
    next_q.burst = next_q.active && next_q.bmode
                   && !next_q.binh
                   && next_q.count >= PDC_BURST_MIN
                   && next_q.addr[3:2] == 2'b00;
  end

  ////////////////////////////////////////////////////////////////////
  // reset keeps the address and count, clears control state

  always_comb begin
    rst_q       = '0;
    // reserved low bits are forced to zero so they are known after power-up
    rst_q.addr  = q.addr & PDC_ADDR_MASK;
    rst_q.count = q.count & PDC_COUNT_MASK[23:0];
    rst_q.bord  = PDC_RST_BIT;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      q <= rst_q;
    end else begin
      q <= next_q;
    end
  end

  assign wb_dat_out       = q.rdat;
  assign wb_ack_out       = q.ack;
  assign src_ready_out    = q.sready;
  assign dst_data_out     = q.od;
  assign dst_valid_out    = q.ov;
  assign pci_addr_out     = q.addr;
  assign pci_write_out    = q.dir;
  assign sysbus_burst_out = q.burst;
  assign busy_out         = q.active;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);

  logic ctl_wr;
  assign ctl_wr = wr && wb_adr_in == PDC_OFS_CTL && wb_sel_in[0];

  sequence s_take_quiet;
    take && !wr && !q.fclr;
  endsequence

  sequence s_zero_start;
    ctl_wr && wb_dat_in[PDC_CTL_START] && q.count == '0 && !q.active;
  endsequence

  property p_zero_idle;
    s_zero_start |=> !q.active ##1 !src_ready_out;
  endproperty
  a_zero_idle: assert property (p_zero_idle)
    else $error("zero count started a transfer");

  property p_count_step;
    s_take_quiet |=> q.count == $past(q.count) - PDC_STEP;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not fall by one word");

  property p_end;
    s_take_quiet ##0 (q.count == PDC_STEP) |=> !q.active && !q.sready;
  endproperty
  a_end: assert property (p_end)
    else $error("transfer did not end at zero count");

  property p_swap;
    s_take_quiet ##0 !q.bord |=> q.stg_d == swap32($past(src_data_in));
  endproperty
  a_swap: assert property (p_swap)
    else $error("bytes not reversed");

  property p_pass;
    s_take_quiet ##0 q.bord |=> q.stg_d == $past(src_data_in);
  endproperty
  a_pass: assert property (p_pass)
    else $error("word altered with byte order set");

  property p_clear;
    q.fclr |=> f_level == '0 && !f_valid;
  endproperty
  a_clear: assert property (p_clear)
    else $error("fifo not empty under clear");

  property p_addr_step;
    out_go && !wr |=> pci_addr_out == $past(pci_addr_out) + PDC_ASTEP;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("pci-side address did not step");

  property p_no_burst;
    q.binh |-> !sysbus_burst_out;
  endproperty
  a_no_burst: assert property (p_no_burst)
    else $error("burst while inhibited");

  property p_count_align;
    q.count[1:0] == 2'b00 && q.addr[1:0] == 2'b00;
  endproperty
  a_count_align: assert property (p_count_align)
    else $error("reserved low bits set");

endmodule : pdc_engine

//--- testbench/pdc_stream_partner.sv
/*
  pdc_stream_partner: word source and sink facing the engine's streams.
  assumes one clock; the bench raises src_limit_in to release words and
  uses stall_in to hold the sink off.
*/
`timescale 1ns/1ps
module pdc_stream_partner (
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  input  wire logic [31:0] src_limit_in,
  input  wire logic        stall_in,
  input  wire logic        src_ready_in,
  output logic      [31:0] src_data_out,
  output logic             src_valid_out,
  input  wire logic [31:0] dst_data_in,
  input  wire logic        dst_valid_in,
  output logic             dst_ready_out
);
  int unsigned tx_cnt;
  int unsigned rx_cnt;
  logic [31:0] rx_mem [0:63];
  logic [31:0] word;

  assign word = 32'h0102_0304 + 32'(tx_cnt) * 32'h1010_1010;
  // idle data shows the inverse so a stale word is never taken for valid
  assign src_data_out = src_valid_out ? word : ~word;
  assign dst_ready_out = !stall_in;

  ////////////////////////////////////////////////////////////////////////
  // source holds each word until taken
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      tx_cnt <= 0;
      src_valid_out <= 1'b0;
    end else if (src_valid_out && src_ready_in) begin
      tx_cnt <= tx_cnt + 1;
      src_valid_out <= (tx_cnt + 1 < src_limit_in);
    end else if (!src_valid_out) begin
      src_valid_out <= (tx_cnt < src_limit_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sink records words in arrival order
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rx_cnt <= 0;
    end else if (dst_valid_in && dst_ready_out) begin
      rx_mem[rx_cnt[5:0]] <= dst_data_in;
      rx_cnt <= rx_cnt + 1;
    end
  end
endmodule : pdc_stream_partner

//--- testbench/pci_dma_address_count_config_bench.sv
/*
  bench for pdc_engine: register table rows, then reset retention,
  zero count, swapped and plain transfers, fifo clear.
  assumes pdc_stream_partner on the streams, wishbone driven here.
*/
`timescale 1ns/1ps
module pci_dma_address_count_config_bench;
  import pdc_pkg::*;
  typedef struct packed {
    logic [15:0] adr;
    logic [31:0] wdat;
    logic [31:0] exp;
  } pdc_row_s;

  logic        clock_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic [31:0] sdat, ddat, paddr, rd;
  logic        svld, srdy, dvld, drdy, pwr, burst, busy;
  logic [31:0] limit = 32'h0000_0000;
  logic        stall = 1'b0;
  int          mismatches = 0;
  int          cmp_count = 0;
  pdc_row_s    rows [5] = '{
    '{PDC_OFS_ADDR, 32'hFFFF_FFFF, 32'hFFFF_FFFC},
    '{PDC_OFS_COUNT, 32'hFFFF_FFFF, 32'h00FF_FFFC},
    '{PDC_OFS_CFG, 32'hFFFF_FFFF, 32'h0038_0000},
    '{PDC_OFS_CFG, 32'h0000_0000, 32'h0000_0000},
    '{16'hD21C, 32'h1234_5678, 32'h0000_0000}};

  always #5 clock_in = ~clock_in;

  pdc_engine #(.FIFO_DEPTH(32)) uut (
    .clock_in(clock_in), .srst_in(srst_in), .wb_cyc_in(cyc),
    .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat),
    .wb_sel_in(4'hF), .wb_dat_out(rdat), .wb_ack_out(ack),
    .src_data_in(sdat), .src_valid_in(svld), .src_ready_out(srdy),
    .dst_data_out(ddat), .dst_valid_out(dvld), .dst_ready_in(drdy),
    .pci_addr_out(paddr), .pci_write_out(pwr),
    .sysbus_burst_out(burst), .busy_out(busy));

  pdc_stream_partner part (
    .clock_in(clock_in), .srst_in(srst_in), .src_limit_in(limit),
    .stall_in(stall), .src_ready_in(srdy), .src_data_out(sdat),
    .src_valid_out(svld), .dst_data_in(ddat), .dst_valid_in(dvld),
    .dst_ready_out(drdy));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // entered just after a rising edge; waits for ack without assuming latency
  task automatic wb(input logic w, input logic [15:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    chk("wb_ack", 32'h1, 32'(ack));
    cyc <= 1'b0;
    @(posedge clock_in);
  endtask : wb

  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (part.rx_cnt < n && k < 500) begin
      @(posedge clock_in);
      k++;
    end
    repeat (4) @(posedge clock_in);
    chk("rx_count", 32'(n), 32'(part.rx_cnt));
  endtask : wait_rx

  // count always whole words of the transfer size
  task automatic xfer(input logic [31:0] cfg, input logic [31:0] base,
                      input int nw, input logic [31:0] ctl);
    wb(1'b1, PDC_OFS_CFG, cfg);
    wb(1'b1, PDC_OFS_ADDR, base);
    wb(1'b1, PDC_OFS_COUNT, 32'(nw * 4));
    wb(1'b1, PDC_OFS_CTL, ctl);
    repeat (2) @(posedge clock_in);
  endtask : xfer

  task automatic chk_rx(input int first, input int n, input logic plain);
    logic [31:0] w;
    for (int i = first; i < first + n; i++) begin
      w = 32'h0102_0304 + 32'(i) * 32'h1010_1010;
      if (!plain) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
      chk("rx_word", w, part.rx_mem[i]);
    end
  endtask : chk_rx

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock_in);
    mismatches++;
    $display("CHECK FAILED watchdog expected done seen hang");
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    foreach (rows[i]) begin
      wb(1'b1, rows[i].adr, rows[i].wdat);
      wb(1'b0, rows[i].adr, 32'h0);
      chk("reg_row", rows[i].exp, rd);
    end
    // address and count written before a mid-run reset must survive it; the configuration must clear
    wb(1'b1, PDC_OFS_ADDR, 32'h1234_5678);
    wb(1'b1, PDC_OFS_COUNT, 32'h0000_0040);
    wb(1'b1, PDC_OFS_CFG, 32'h0010_0000);
    srst_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    wb(1'b0, PDC_OFS_ADDR, 32'h0);
    chk("addr_kept", 32'h1234_5678, rd);
    wb(1'b0, PDC_OFS_COUNT, 32'h0);
    chk("count_kept", 32'h0000_0040, rd);
    wb(1'b0, PDC_OFS_CFG, 32'h0);
    chk("cfg_reset", 32'h0, rd);
    xfer(32'h0, 32'h0000_0100, 0, 32'h3);
    chk("zero_busy", 32'h0, 32'(busy));
    // swapped transfer with bursts allowed
    xfer(32'h0, 32'h0000_0100, 4, 32'h7);
    chk("burst_on", 32'h1, 32'(burst));
    chk("pci_write", 32'h1, 32'(pwr));
    limit <= 32'd4;
    wait_rx(4);
    chk("busy_end", 32'h0, 32'(busy));
    chk("pci_addr", 32'h0000_0110, paddr);
    wb(1'b0, PDC_OFS_COUNT, 32'h0);
    chk("count_end", 32'h0, rd);
    chk_rx(0, 4, 1'b0);
    // pass-through order, bursts inhibited, pci read direction
    xfer(32'h0018_0000, 32'h0000_0200, 4, 32'h5);
    chk("burst_off", 32'h0, 32'(burst));
    chk("pci_read", 32'h0, 32'(pwr));
    limit <= 32'd8;
    wait_rx(8);
    chk_rx(4, 4, 1'b1);
    // clear the fifo while the sink is stalled
    stall <= 1'b1;
    xfer(32'h0, 32'h0000_0300, 2, 32'h1);
    limit <= 32'd10;
    repeat (20) @(posedge clock_in);
    wb(1'b1, PDC_OFS_CFG, 32'h0020_0000);
    wb(1'b0, PDC_OFS_STAT, 32'h0);
    chk("fifo_level", 32'h0, rd & 32'h0000_3F00);
    wb(1'b1, PDC_OFS_CFG, 32'h0);
    tally_and_finish();
  end
endmodule : pci_dma_address_count_config_bench
